// File: logic/core_timing_pkg.sv
/*
  Constants for the core memory cycle timing sequencer: times in
  nanoseconds and the derived cycle counts at the 200 MHz clock.
  Assumes mclk runs at 200 MHz (5 ns period).
*/
package core_timing_pkg;

  localparam int ClkPeriodNs = 5;

  // Read X-driver gate width, 7.6 to 9.9 us, nominal 8.7 us
  localparam int XGateMinNs = 7600;
  localparam int XGateMaxNs = 9900;
  localparam int XGateNs = 8700;
  localparam int XGateCycles = XGateNs / ClkPeriodNs;

  // Y-driver gate delay 2.5 us +/- 0.36 us
  localparam int YDelayNs = 2500;
  localparam int YDelayCycles = YDelayNs / ClkPeriodNs;

  // Y-driver gate width 5.3 to 7.7 us
  localparam int YGateMinNs = 5300;
  localparam int YGateMaxNs = 7700;
  localparam int YGateNs = 6500;
  localparam int YGateCycles = YGateNs / ClkPeriodNs;

  // Write driver gate delay 0.56 to 1.82 us, nominal 1.19 us
  localparam int WDelayNs = 1190;
  localparam int WDelayCycles = WDelayNs / ClkPeriodNs;

  // Write driver gate width 7.6 to 9.9 us
  localparam int WGateNs = 8700;
  localparam int WGateCycles = WGateNs / ClkPeriodNs;

  // Strobe blanking 0.9 to 1.1 us after Y gate rises
  localparam int BlankNs = 1000;
  localparam int BlankCycles = BlankNs / ClkPeriodNs;

  // Data one-shot width 7 us +/- 3
  localparam int DataPulseNs = 7000;
  localparam int DataPulseCycles = DataPulseNs / ClkPeriodNs;

  // Frame ID delay to data one-shot, 0.34 to 1.04 us
  localparam int FrameDelayNs = 690;
  localparam int FrameDelayCycles = (FrameDelayNs + ClkPeriodNs - 1) / ClkPeriodNs;

  localparam int CntW = 12;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_XONLY = 3'b010,
    RD_XY = 3'b100
  } read_state_t;

endpackage

// File: logic/one_shot.sv
/*
  Retriggerable-free one-shot: a start pulse, after a delay in cycles,
  raises the output for a width in cycles. Ignores starts while busy.
  Assumes start comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module one_shot
  import core_timing_pkg::*;
#(
  parameter logic [CntW-1:0] Delay = 12'h000,
  parameter logic [CntW-1:0] Width = 12'h001
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  output logic pulse
);

  logic [CntW-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic pulse_q, pulse_d;

  // Next state: count through delay then width
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    pulse_d = pulse_q;
    if (!busy_q) begin
      if (start) begin
        busy_d = 1'b1;
        cnt_d = '0;
        pulse_d = (Delay == '0);
      end
    end else begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q + 1'b1 == Delay) begin
        pulse_d = 1'b1;
      end
      if (cnt_q + 1'b1 == Delay + Width) begin
        pulse_d = 1'b0;
        busy_d = 1'b0;
      end
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;

endmodule
`default_nettype wire

// File: logic/core_memory_cycle_timing.sv
/*
  Core memory read/write cycle timing sequencer, strobe window and
  data output one-shot with frame ID pass-through.
  Assumes command, sense and frame inputs are asynchronous pins and
  the requester keeps its pulse width and repetition limits.
*/
`timescale 1ns/1ps
`default_nettype none
module core_memory_cycle_timing
  import core_timing_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic readRequest,
  input wire logic writeRequest,
  input wire logic sensedOne,
  input wire logic frameId,
  input wire logic readAddress,
  input wire logic writeAddress,
  output logic read_switch_gate,
  output logic read_x_driver_gate,
  output logic read_y_driver_gate,
  output logic write_switch_gate,
  output logic write_driver_gate,
  output logic selectSwitchOn,
  output logic dataOut
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] syncA_q, syncB_q;
  logic rdReq, wrReq, sense, frame, rdAddr, wrAddr;

  // Two flops on every pin input
  always_ff @(posedge mclk) begin
    if (reset) begin
      syncA_q <= 6'h00;
      syncB_q <= 6'h00;
    end else begin
      syncA_q <= {readRequest, writeRequest, sensedOne, frameId, readAddress, writeAddress};
      syncB_q <= syncA_q;
    end
  end

  assign {rdReq, wrReq, sense, frame, rdAddr, wrAddr} = syncB_q;

  // Edge history of synchronised levels
  logic xGate, yGate, wGate, blankDone, dataShot, frameShot;
  logic rdReqPrev_q, wrReqPrev_q, framePrev_q, yPrev_q;
  logic rdRise, wrRise, frameRise, yRise;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdReqPrev_q <= 1'b0;
      wrReqPrev_q <= 1'b0;
      framePrev_q <= 1'b0;
      yPrev_q <= 1'b0;
    end else begin
      rdReqPrev_q <= rdReq;
      wrReqPrev_q <= wrReq;
      framePrev_q <= frame;
      yPrev_q <= yGate;
    end
  end

  assign rdRise = rdReq & ~rdReqPrev_q;
  assign wrRise = wrReq & ~wrReqPrev_q;
  assign frameRise = frame & ~framePrev_q;

  // ----------------------------------------------------------------
  // Read sequence
  // ----------------------------------------------------------------
  // X driver gate one-shot, starts with the read request
  one_shot #(
    .Delay(12'h000),
    .Width(CntW'(XGateCycles))
  ) xShot (
    .mclk(mclk),
    .reset(reset),
    .start(rdRise),
    .pulse(xGate)
  );

  // Y driver gate, delayed from X rising
  one_shot #(
    .Delay(CntW'(YDelayCycles)),
    .Width(CntW'(YGateCycles))
  ) yShot (
    .mclk(mclk),
    .reset(reset),
    .start(rdRise),
    .pulse(yGate)
  );

  assign yRise = yGate & ~yPrev_q;

  // ----------------------------------------------------------------
  // Write sequence
  // ----------------------------------------------------------------
  // Driver gate delayed from the switch gate, fixed width
  one_shot #(
    .Delay(CntW'(WDelayCycles)),
    .Width(CntW'(WGateCycles))
  ) wShot (
    .mclk(mclk),
    .reset(reset),
    .start(wrRise),
    .pulse(wGate)
  );

  // ----------------------------------------------------------------
  // Strobe window and data one-shot
  // ----------------------------------------------------------------
  // Blanking timer, ends 1 us after Y rises
  one_shot #(
    .Delay(CntW'(BlankCycles)),
    .Width(12'h001)
  ) blankShot (
    .mclk(mclk),
    .reset(reset),
    .start(yRise),
    .pulse(blankDone)
  );

  logic windowOpen_q, windowOpen_d;

  // Window opens after blanking, only with read and Y high
  always_comb begin
    windowOpen_d = windowOpen_q;
    if (!(rdReq && yGate) || yRise) begin
      windowOpen_d = 1'b0;
    end else if (blankDone) begin
      windowOpen_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      windowOpen_q <= 1'b0;
    end else begin
      windowOpen_q <= windowOpen_d;
    end
  end

  // Frame ID delayed into the data one-shot
  one_shot #(
    .Delay(CntW'(FrameDelayCycles)),
    .Width(12'h001)
  ) frameDly (
    .mclk(mclk),
    .reset(reset),
    .start(frameRise),
    .pulse(frameShot)
  );

  logic fire;
  assign fire = (windowOpen_q && rdReq && yGate && sense) || frameShot;

  one_shot #(
    .Delay(12'h000),
    .Width(CntW'(DataPulseCycles))
  ) dataOs (
    .mclk(mclk),
    .reset(reset),
    .start(fire),
    .pulse(dataShot)
  );

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic [6:0] out_q, out_d;

  // Gates and switch selection
  always_comb begin
    out_d[0] = rdReq;
    out_d[1] = xGate;
    out_d[2] = yGate;
    out_d[3] = wrReq;
    out_d[4] = wGate;
    out_d[5] = (rdAddr & rdReq) | (wrAddr & wrReq);
    out_d[6] = dataShot;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      out_q <= 7'h00;
    end else begin
      out_q <= out_d;
    end
  end

  assign read_switch_gate = out_q[0];
  assign read_x_driver_gate = out_q[1];
  assign read_y_driver_gate = out_q[2];
  assign write_switch_gate = out_q[3];
  assign write_driver_gate = out_q[4];
  assign selectSwitchOn = out_q[5];
  assign dataOut = out_q[6];

endmodule
`default_nettype wire

// File: test/core_timing_asserts.sv
/* Checker for the core cycle sequencer.
   Sees top ports only; 200 MHz mclk. */
`timescale 1ns/1ps
`default_nettype none
module core_timing_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire logic readRequest,
  input wire logic writeRequest,
  input wire logic readAddress,
  input wire logic writeAddress,
  input wire logic read_switch_gate,
  input wire logic read_x_driver_gate,
  input wire logic read_y_driver_gate,
  input wire logic write_switch_gate,
  input wire logic write_driver_gate,
  input wire logic selectSwitchOn,
  input wire logic dataOut
);
  // High run lengths of the one-shots
  logic [11:0] xLen, yLen, wLen, dLen;
  always_ff @(posedge mclk) begin
    xLen <= read_x_driver_gate ? xLen + 12'h001 : 12'h000;
    yLen <= read_y_driver_gate ? yLen + 12'h001 : 12'h000;
    wLen <= write_driver_gate ? wLen + 12'h001 : 12'h000;
    dLen <= dataOut ? dLen + 12'h001 : 12'h000;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_RD_SWITCH: assert property (read_switch_gate == $past(readRequest, 3))
    else $error("read switch gate off request");
  AST_WR_SWITCH: assert property (write_switch_gate == $past(writeRequest, 3))
    else $error("write switch gate off request");
  AST_X_START: assert property ($rose(read_switch_gate) && !read_x_driver_gate |-> ##[1:2] read_x_driver_gate)
    else $error("x gate did not start");
  AST_X_WIDTH: assert property ($fell(read_x_driver_gate) |-> xLen >= 12'h5f0 && xLen <= 12'h7bc)
    else $error("x gate width");
  AST_Y_DELAY: assert property ($rose(read_x_driver_gate) |-> ##[428:572] $rose(read_y_driver_gate))
    else $error("y gate delay");
  AST_Y_WIDTH: assert property ($fell(read_y_driver_gate) |-> yLen >= 12'h424 && yLen <= 12'h604)
    else $error("y gate width");
  AST_W_DELAY: assert property ($rose(write_switch_gate) && !write_driver_gate |-> ##[112:364] $rose(write_driver_gate))
    else $error("write driver delay");
  AST_W_WIDTH: assert property ($fell(write_driver_gate) |-> wLen >= 12'h5f0 && wLen <= 12'h7bc)
    else $error("write driver width");
  AST_D_WIDTH: assert property ($fell(dataOut) |-> dLen >= 12'h320 && dLen <= 12'h7d0)
    else $error("data pulse width");
  AST_SELECT: assert property (selectSwitchOn == $past(readAddress && readRequest || writeAddress && writeRequest, 3))
    else $error("select switch");
  cover property ($rose(read_y_driver_gate));
  cover property ($rose(write_driver_gate));
  cover property ($rose(dataOut));
endmodule
bind core_memory_cycle_timing core_timing_asserts core_timing_asserts_inst (.mclk, .reset, .readRequest,
  .writeRequest, .readAddress, .writeAddress, .read_switch_gate, .read_x_driver_gate, .read_y_driver_gate,
  .write_switch_gate, .write_driver_gate, .selectSwitchOn, .dataOut);
`default_nettype wire

// File: test/requester_model.sv
/* Requester model: 11 us read and write commands.
   Start strobes come from the bench on mclk. */
`timescale 1ns/1ps
`default_nettype none
module requester_model (
  input wire logic mclk,
  input wire logic startRead,
  input wire logic startWrite,
  output logic readRequest,
  output logic writeRequest
);
  int rdLeft = 0;
  int wrLeft = 0;
  // Pulse length 2200 cycles; spacing kept by the bench
  always @(posedge mclk) begin
    rdLeft <= startRead ? 2200 : (rdLeft > 0 ? rdLeft - 1 : 0);
    wrLeft <= startWrite ? 2200 : (wrLeft > 0 ? wrLeft - 1 : 0);
  end
  assign readRequest = rdLeft > 0;
  assign writeRequest = wrLeft > 0;
endmodule
`default_nettype wire

// File: test/tb_top.sv
/* Testbench for the core cycle sequencer.
   Requester model drives commands; 200 MHz mclk. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic startRead = 1'b0;
  logic startWrite = 1'b0;
  logic sensedOne = 1'b0;
  logic frameId = 1'b0;
  logic readAddress = 1'b1;
  logic writeAddress = 1'b0;
  logic readRequest, writeRequest;
  wire [6:0] outs;
  int bad_count = 0;
  int compares = 0;
  int n;
  requester_model requester_model_inst (.mclk, .startRead, .startWrite, .readRequest, .writeRequest);
  core_memory_cycle_timing core_memory_cycle_timing_inst (.mclk, .reset, .readRequest, .writeRequest,
    .sensedOne, .frameId, .readAddress, .writeAddress, .read_switch_gate(outs[0]), .read_x_driver_gate(outs[1]),
    .read_y_driver_gate(outs[2]), .write_switch_gate(outs[3]), .write_driver_gate(outs[4]),
    .selectSwitchOn(outs[5]), .dataOut(outs[6]));
  // ----------------
  // Shared tasks
  // ----------------
  task automatic tick(int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check_bit(string what, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_span(string what, int lo, int hi, int got);
    compares++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic wait_lvl(int i, logic v, int lim);
    n = 0;
    while (outs[i] !== v && n < lim) begin
      tick();
      n++;
    end
    if (outs[i] !== v) begin
      bad_count++;
      $display("mismatch output %0d expected %b seen timeout", i, v);
      report_and_stop();
    end
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic test_idle_sense;
    sensedOne = 1'b1;
    tick(50);
    check_bit("dataOut idle", 1'b0, outs[6]);
    sensedOne = 1'b0;
    $display("idle sense done");
  endtask
  task automatic test_read;
    startRead = 1'b1;
    tick();
    startRead = 1'b0;
    wait_lvl(0, 1'b1, 10);
    check_bit("selectSwitchOn read", 1'b1, outs[5]);
    wait_lvl(1, 1'b1, 4);
    wait_lvl(2, 1'b1, 1000);
    check_span("y delay", 428, 572, n);
    tick(100);
    sensedOne = 1'b1;
    tick(20);
    sensedOne = 1'b0;
    check_bit("dataOut blanked", 1'b0, outs[6]);
    tick(280);
    sensedOne = 1'b1;
    wait_lvl(6, 1'b1, 40);
    sensedOne = 1'b0;
    wait_lvl(6, 1'b0, 2100);
    check_span("data width", 800, 2000, n);
    wait_lvl(0, 1'b0, 2600);
    $display("read done");
  endtask
  task automatic test_write;
    startWrite = 1'b1;
    tick();
    startWrite = 1'b0;
    wait_lvl(3, 1'b1, 10);
    check_bit("selectSwitchOn write", 1'b0, outs[5]);
    wait_lvl(4, 1'b1, 400);
    check_span("write delay", 112, 364, n);
    writeAddress = 1'b1;
    tick(4);
    check_bit("selectSwitchOn addr", 1'b1, outs[5]);
    wait_lvl(4, 1'b0, 2100);
    check_span("write width", 1520, 1980, n + 4);
    $display("write done");
  endtask
  task automatic test_frame;
    frameId = 1'b1;
    wait_lvl(6, 1'b1, 300);
    check_span("frame delay", 68, 208, n);
    tick(1000 - n);
    frameId = 1'b0;
    wait_lvl(6, 1'b0, 2100);
    $display("frame done");
  endtask
  // Clock and main sequence
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    tick(3);
    reset = 1'b0;
    test_idle_sense();
    test_read();
    test_write();
    test_frame();
    report_and_stop();
  end
endmodule
`default_nettype wire
